/* hdl/cpag_defines.vh */
// constants for the coefficient pointer address generator
`ifndef CPAG_DEFINES_VH
`define CPAG_DEFINES_VH
// ***************************************************************
// register byte offsets
// ***************************************************************
`define CPAG_OFS_PTR_LOW   8'h00
`define CPAG_OFS_PTR_HIGH  8'h04
`define CPAG_OFS_BUF_START 8'h08
`define CPAG_OFS_CONFIG    8'h0C
`define CPAG_OFS_LAST_ADDR 8'h10
// ***************************************************************
// reset values and fields
// ***************************************************************
`define CPAG_RST_PTR_LOW   16'h0000
`define CPAG_RST_PTR_HIGH  7'h00
`define CPAG_RST_BUF_START 16'h0000
`define CPAG_CFG_CIRC_BIT  0
// ***************************************************************
// operand modes
// ***************************************************************
`define CPAG_MODE_PLAIN    3'h0
`define CPAG_MODE_POSTINC  3'h1
`define CPAG_MODE_POSTDEC  3'h2
`define CPAG_MODE_INDEXED  3'h3
`define CPAG_MODE_PREADD   3'h4
// ***************************************************************
// access spaces, register classes, bit limits and address steps
// ***************************************************************
`define CPAG_SPACE_DATA    2'h0
`define CPAG_SPACE_MMR     2'h1
`define CPAG_SPACE_REGBIT  2'h2
`define CPAG_SPACE_IO      2'h3
`define CPAG_RC_ACC        2'h0
`define CPAG_RC_AUX        2'h1
`define CPAG_RC_TEMP       2'h2
`define CPAG_RC_OTHER      2'h3
`define CPAG_MAXBIT_ACC    6'h27
`define CPAG_MAXBIT_NARROW 6'h0F
`define CPAG_STEP_SINGLE   23'h000001
`define CPAG_STEP_DOUBLE   23'h000002
`endif

/* hdl/cpag_top.v */
// coefficient pointer address generator with ahb-lite register slave
//
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "cpag_defines.vh"
module cpag_top (
  input  wire        ref_clk_in,
  input  wire        sys_rst_in,
  input  wire        hsel_in,
  input  wire [31:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire        hready_in,
  input  wire [31:0] hwdata_in,
  output reg  [31:0] hrdata_out,
  output reg         hreadyout_out,
  output reg         hresp_out,
  input  wire        req_valid_in,
  input  wire [2:0]  req_mode_in,
  input  wire [1:0]  req_space_in,
  input  wire        req_double_in,
  input  wire        req_bitop_in,
  input  wire [1:0]  req_regclass_in,
  input  wire [15:0] req_const_in,
  input  wire        req_parallel_in,
  output reg         ack_out,
  output reg         refuse_out,
  output reg         pair_refuse_out,
  output reg  [22:0] data_addr_out,
  output reg         data_valid_out,
  output reg  [15:0] io_addr_out,
  output reg         io_valid_out,
  output reg  [5:0]  bit_num_out,
  output reg         bit_valid_out
);
  // ***************************************************************
  // registers
  // ***************************************************************
  reg [15:0] ptr_low_q;
  reg [6:0]  ptr_high_q;
  reg [15:0] buf_start_q;
  reg        circ_en_q;
  reg [22:0] last_addr_q;
  reg        wr_pend_q;
  reg [7:0]  wr_addr_q;

  // ***************************************************************
  // functions
  // ***************************************************************
  function [22:0] sext16;
    input [15:0] k;
    begin
      sext16 = {{7{k[15]}}, k};
    end
  endfunction

  function [31:0] rd_mux;
    input [7:0]  a;
    input [15:0] lo;
    input [6:0]  hi;
    input [15:0] bs;
    input        ce;
    input [22:0] la;
    begin
      case (a)
        `CPAG_OFS_PTR_LOW:   rd_mux = {16'h0000, lo};
        `CPAG_OFS_PTR_HIGH:  rd_mux = {25'h0000000, hi};
        `CPAG_OFS_BUF_START: rd_mux = {16'h0000, bs};
        `CPAG_OFS_CONFIG:    rd_mux = {31'h00000000, ce};
        `CPAG_OFS_LAST_ADDR: rd_mux = {9'h000, la};
        default:             rd_mux = 32'h00000000;
      endcase
    end
  endfunction

  // ***************************************************************
  // address generation
  // ***************************************************************
  reg [22:0] xptr;
  reg [22:0] koff;
  reg [22:0] step;
  reg [22:0] base;
  reg [22:0] new_ptr;
  reg [22:0] daddr;
  reg [15:0] ioaddr;
  reg [5:0]  maxbit;
  reg        const_mode;
  reg        bad;
  reg        upd;

  always @* begin
    xptr       = {ptr_high_q, ptr_low_q};
    koff       = sext16(req_const_in);
    step       = `CPAG_STEP_SINGLE;
    if (req_double_in) begin
      step = `CPAG_STEP_DOUBLE;
    end
    base       = xptr;
    new_ptr    = xptr;
    upd        = 1'b0;
    const_mode = 1'b0;
    bad        = 1'b0;
    case (req_mode_in)
      `CPAG_MODE_PLAIN: begin
        upd = 1'b0;
      end
      `CPAG_MODE_POSTINC: begin
        new_ptr = xptr + step;
        upd     = 1'b1;
      end
      `CPAG_MODE_POSTDEC: begin
        new_ptr = xptr - step;
        upd     = 1'b1;
      end
      `CPAG_MODE_INDEXED: begin
        base       = xptr + koff;
        const_mode = 1'b1;
        bad        = (req_space_in == `CPAG_SPACE_IO);
      end
      `CPAG_MODE_PREADD: begin
        base       = xptr + koff;
        new_ptr    = xptr + koff;
        upd        = 1'b1;
        const_mode = 1'b1;
        bad        = (req_space_in == `CPAG_SPACE_IO);
      end
      default: begin
        bad = 1'b1;
      end
    endcase
    // start only when circular; sum range left to software
    daddr  = circ_en_q ? (base + {7'h00, buf_start_q}) : base;
    ioaddr = circ_en_q ? (ptr_low_q + buf_start_q) : ptr_low_q;
    maxbit = (req_regclass_in == `CPAG_RC_ACC) ? `CPAG_MAXBIT_ACC : `CPAG_MAXBIT_NARROW;
    if (req_double_in) begin
      maxbit = maxbit - 6'h01;
    end
    if (req_space_in == `CPAG_SPACE_REGBIT) begin
      if (!req_bitop_in || (req_regclass_in == `CPAG_RC_OTHER)) begin
        bad = 1'b1;
      end
      // offset modes name the bit through the sum, not the bare pointer
      if ((base[15:6] != 10'h000) || (base[5:0] > maxbit)) begin
        bad = 1'b1;
      end
    end
    if (const_mode && req_parallel_in) begin
      bad = 1'b1;
    end
  end

  // ***************************************************************
  // request handling
  // ***************************************************************
  wire go = req_valid_in && !bad;

  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ack_out         <= 1'b0;
      refuse_out      <= 1'b0;
      pair_refuse_out <= 1'b0;
      data_addr_out   <= 23'h000000;
      data_valid_out  <= 1'b0;
      io_addr_out     <= 16'h0000;
      io_valid_out    <= 1'b0;
      bit_num_out     <= 6'h00;
      bit_valid_out   <= 1'b0;
      last_addr_q     <= 23'h000000;
    end else begin
      ack_out         <= go;
      refuse_out      <= req_valid_in && bad;
      pair_refuse_out <= req_valid_in && const_mode && req_parallel_in;
      data_valid_out  <= go && ((req_space_in == `CPAG_SPACE_DATA) ||
                                (req_space_in == `CPAG_SPACE_MMR));
      io_valid_out    <= go && (req_space_in == `CPAG_SPACE_IO);
      bit_valid_out   <= go && (req_space_in == `CPAG_SPACE_REGBIT);
      if (go) begin
        data_addr_out <= daddr;
        io_addr_out   <= ioaddr;
        bit_num_out   <= base[5:0];
        last_addr_q   <= daddr;
      end
    end
  end

  // ***************************************************************
  // ahb-lite slave
  // ***************************************************************
  wire       acc_take = hsel_in && hready_in && htrans_in[1];
  wire [7:0] acc_ofs  = haddr_in[7:0];

  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      hrdata_out    <= 32'h00000000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      wr_pend_q     <= 1'b0;
      wr_addr_q     <= 8'h00;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      wr_pend_q     <= acc_take && hwrite_in;
      if (acc_take) begin
        wr_addr_q <= acc_ofs;
      end
      // read data is latched in the address phase, shown in the data phase
      if (acc_take && !hwrite_in) begin
        hrdata_out <= rd_mux(acc_ofs, ptr_low_q, ptr_high_q, buf_start_q,
                             circ_en_q, last_addr_q);
      end else begin
        hrdata_out <= 32'h00000000;
      end
    end
  end

  // ***************************************************************
  // pointer and configuration registers
  // ***************************************************************
  // a bus write lands in the same cycle as a pointer update and wins,
  // so software setup is never lost to a stray request
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ptr_low_q   <= `CPAG_RST_PTR_LOW;
      ptr_high_q  <= `CPAG_RST_PTR_HIGH;
      buf_start_q <= `CPAG_RST_BUF_START;
      circ_en_q   <= 1'b0;
    end else begin
      if (go && upd) begin
        ptr_low_q  <= new_ptr[15:0];
        ptr_high_q <= new_ptr[22:16];
      end
      if (wr_pend_q) begin
        case (wr_addr_q)
          `CPAG_OFS_PTR_LOW:   ptr_low_q   <= hwdata_in[15:0];
          `CPAG_OFS_PTR_HIGH:  ptr_high_q  <= hwdata_in[6:0];
          `CPAG_OFS_BUF_START: buf_start_q <= hwdata_in[15:0];
          `CPAG_OFS_CONFIG:    circ_en_q   <= hwdata_in[`CPAG_CFG_CIRC_BIT];
          default: begin
          end
        endcase
      end
    end
  end

endmodule // cpag_top
`default_nettype wire

/* testbench/cpag_top_sva.sv */
// request port assertions for the coefficient pointer address generator
`timescale 1ns/10ps
`default_nettype none
module cpag_top_sva (
  input wire logic       ref_clk_in,
  input wire logic       sys_rst_in,
  input wire logic       req_valid_in,
  input wire logic [2:0] req_mode_in,
  input wire logic [1:0] req_space_in,
  input wire logic       req_bitop_in,
  input wire logic [1:0] req_regclass_in,
  input wire logic       req_parallel_in,
  input wire logic       ack_out,
  input wire logic       refuse_out,
  input wire logic       pair_refuse_out,
  input wire logic       data_valid_out,
  input wire logic       io_valid_out,
  input wire logic [5:0] bit_num_out,
  input wire logic       bit_valid_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  wire logic konst = req_valid_in && (req_mode_in == 3'h3 || req_mode_in == 3'h4);
  a_one_answer: assert property (req_valid_in |=> ack_out != refuse_out)
    else $error("request not answered exactly once");
  a_no_answer: assert property (!req_valid_in |=> !ack_out && !refuse_out)
    else $error("answer without request");
  a_io_no_const: assert property (konst && req_space_in == 2'h3 |=> refuse_out && !io_valid_out)
    else $error("constant operand accepted for io");
  a_pair_refused: assert property (konst && req_parallel_in |=> pair_refuse_out && refuse_out)
    else $error("parallel constant operand not refused");
  a_pair_cause: assert property (pair_refuse_out |-> $past(konst && req_parallel_in))
    else $error("pairing refusal without cause");
  a_bit_class: assert property (req_valid_in && req_space_in == 2'h2 &&
    (!req_bitop_in || req_regclass_in == 2'h3) |=> refuse_out && !bit_valid_out)
    else $error("bit access accepted for wrong op or register");
  a_bad_mode: assert property (req_valid_in && req_mode_in > 3'h4 |=> refuse_out)
    else $error("undefined operand accepted");
  a_io_plain: assert property (req_valid_in && req_space_in == 2'h3 && req_mode_in < 3'h3
    |=> ack_out && io_valid_out && !data_valid_out)
    else $error("io access not issued");
  a_data_go: assert property (req_valid_in && req_space_in < 2'h2 && req_mode_in < 3'h5 &&
    !(konst && req_parallel_in) |=> ack_out && data_valid_out && !io_valid_out)
    else $error("data space access not issued");
  a_bit_range: assert property (bit_valid_out |-> bit_num_out <= 6'h27 &&
    ($past(req_regclass_in) == 2'h0 || bit_num_out <= 6'h0F))
    else $error("bit number beyond register");
  c_io: cover property (io_valid_out);
  c_pair: cover property (pair_refuse_out);
  c_bit: cover property (bit_valid_out);
endmodule // cpag_top_sva
bind cpag_top cpag_top_sva cpag_top_sva_inst (.ref_clk_in, .sys_rst_in, .req_valid_in,
  .req_mode_in, .req_space_in, .req_bitop_in, .req_regclass_in, .req_parallel_in, .ack_out,
  .refuse_out, .pair_refuse_out, .data_valid_out, .io_valid_out, .bit_num_out, .bit_valid_out);
`default_nettype wire

/* testbench/cpag_bus_sink.sv */
// far-side model: cpu address buses latching each presented address
`timescale 1ns/10ps
`default_nettype none
module cpag_bus_sink (
  input  wire logic        ref_clk_in,
  input  wire logic        data_valid_in,
  input  wire logic [22:0] data_addr_in,
  input  wire logic        io_valid_in,
  input  wire logic [15:0] io_addr_in,
  output var  logic [22:0] data_seen_out,
  output var  logic [15:0] io_seen_out
);
  // one data bus, 16-bit io bus
  always @(posedge ref_clk_in) begin
    if (data_valid_in) data_seen_out <= data_addr_in;
    if (io_valid_in) io_seen_out <= io_addr_in;
  end
endmodule // cpag_bus_sink
`default_nettype wire

/* testbench/cpag_top_test.sv */
// self-checking bench for the coefficient pointer address generator
`timescale 1ns/10ps
`default_nettype none
`include "cpag_defines.vh"
module cpag_top_test;
  localparam logic [7:0] pl = `CPAG_OFS_PTR_LOW, ph = `CPAG_OFS_PTR_HIGH;
  localparam logic [7:0] bs = `CPAG_OFS_BUF_START, cf = `CPAG_OFS_CONFIG;
  logic ref_clk_in = 1'b0, sys_rst_in = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic rv = 1'b0, rdb = 1'b0, rb = 1'b0, rp = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0, rs = 2'h0, rc = 2'h0;
  logic [2:0] rm = 3'h0;
  logic [15:0] rk = 16'h0;
  wire logic [31:0] hrdata;
  wire logic hrdy, hresp, ack, rf, prf, dv, iv, bv;
  wire logic [22:0] da, sda;
  wire logic [15:0] ia, sia;
  wire logic [5:0] bn;
  int miscompares = 0, check_count = 0;
  always #2 ref_clk_in = ~ref_clk_in;
  cpag_top cpag_top_inst (.ref_clk_in, .sys_rst_in, .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(hrdy),
    .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
    .req_valid_in(rv), .req_mode_in(rm), .req_space_in(rs), .req_double_in(rdb),
    .req_bitop_in(rb), .req_regclass_in(rc), .req_const_in(rk), .req_parallel_in(rp),
    .ack_out(ack), .refuse_out(rf), .pair_refuse_out(prf), .data_addr_out(da),
    .data_valid_out(dv), .io_addr_out(ia), .io_valid_out(iv), .bit_num_out(bn),
    .bit_valid_out(bv));
  cpag_bus_sink cpag_bus_sink_inst (.ref_clk_in, .data_valid_in(dv), .data_addr_in(da),
    .io_valid_in(iv), .io_addr_in(ia), .data_seen_out(sda), .io_seen_out(sia));
  // ************************************
  // tasks
  // ************************************
  task automatic stop_test;
    $display("mismatches %0d checks %0d", miscompares, check_count);
    if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // bounded wait for hready sampled high at an edge
  task automatic hw;
    int i;
    i = 0;
    do begin
      @(posedge ref_clk_in);
      i++;
    end while (hrdy !== 1'b1 && i < 50);
    if (hrdy !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t hready timeout", $time);
      stop_test;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge ref_clk_in);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    hw;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hw;
    q = hrdata;
    // response must stay okay on every transfer
    ck({31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    ck(q, e);
  endtask
  // flags f = {ack, refuse, pair refuse, data, io, bit}
  task automatic rq(input logic [2:0] m, input logic [1:0] s, input logic [1:0] c,
                    input logic d, input logic b, input logic p, input logic [15:0] k,
                    input logic [5:0] f);
    @(posedge ref_clk_in);
    rv <= 1'b1;
    rm <= m;
    rs <= s;
    rc <= c;
    rdb <= d;
    rb <= b;
    rp <= p;
    rk <= k;
    @(posedge ref_clk_in);
    rv <= 1'b0;
    #1;
    ck({26'h0, ack, rf, prf, dv, iv, bv}, {26'h0, f});
  endtask
  // ************************************
  // sequence
  // ************************************
  initial begin
    repeat (5) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    for (int a = 0; a < 24; a += 4) rdc(a[7:0], 32'h0); // reset values, unmapped 14h
    wr(ph, 32'h5);
    wr(pl, 32'hFFFF);
    rq(0, 0, 0, 0, 0, 0, 0, 6'h24);
    ck(da, 32'h05FFFF);
    rq(1, 1, 0, 0, 0, 0, 0, 6'h24);
    ck(da, 32'h05FFFF);
    rq(0, 0, 0, 0, 0, 0, 0, 6'h24);
    ck(da, 32'h060000);
    rq(2, 0, 0, 1, 0, 0, 0, 6'h24);
    rq(0, 0, 0, 0, 0, 0, 0, 6'h24);
    ck(da, 32'h05FFFE);
    rq(1, 0, 0, 1, 0, 0, 0, 6'h24);
    rq(0, 0, 0, 0, 0, 0, 0, 6'h24);
    ck(da, 32'h060000);
    wr(ph, 32'h7F);
    wr(pl, 32'hFFFF);
    rq(1, 0, 0, 0, 0, 0, 0, 6'h24);
    rdc(ph, 32'h0);
    rq(3, 0, 0, 0, 0, 0, 16'hFFFE, 6'h24);
    ck(da, 32'h7FFFFE);
    rq(0, 0, 0, 0, 0, 0, 0, 6'h24);
    ck(da, 32'h0);
    rq(4, 0, 0, 0, 0, 0, 16'h0010, 6'h24);
    ck(da, 32'h10);
    rdc(pl, 32'h10);
    rq(3, 0, 0, 0, 0, 1, 16'h5, 6'h18);
    rq(4, 3, 0, 0, 0, 0, 16'h5, 6'h10);
    for (int m = 5; m < 8; m++) rq(m[2:0], 0, 0, 0, 0, 0, 0, 6'h10);
    wr(ph, 32'h3);
    rq(0, 3, 0, 0, 0, 0, 0, 6'h22);
    // the bus model latches one edge after the valid pulse
    @(posedge ref_clk_in);
    #1;
    ck(sia, 32'h10);
    wr(bs, 32'h0100);
    wr(cf, 32'h1);
    rq(0, 0, 0, 0, 0, 0, 0, 6'h24);
    @(posedge ref_clk_in);
    #1;
    ck(sda, 32'h030110);
    rdc(`CPAG_OFS_LAST_ADDR, 32'h030110);
    wr(cf, 32'h0);
    wr(pl, 32'd39);
    rq(0, 2, 0, 0, 1, 0, 0, 6'h21);
    ck(bn, 32'd39);
    rq(0, 2, 0, 1, 1, 0, 0, 6'h10);
    for (int c = 1; c < 4; c++) rq(0, 2, c[1:0], 0, 1, 0, 0, 6'h10);
    rq(0, 2, 0, 0, 0, 0, 0, 6'h10);
    wr(pl, 32'd14);
    rq(1, 2, 1, 0, 1, 0, 0, 6'h21);
    for (int c = 0; c < 3; c++) rq(0, 2, c[1:0], 0, 1, 0, 0, 6'h21);
    ck(bn, 32'd15);
    rq(3, 2, 0, 0, 1, 0, 16'h0018, 6'h21);
    ck(bn, 32'd39);
    rq(4, 2, 1, 0, 1, 0, 16'hFFFF, 6'h21);
    ck(bn, 32'd14);
    stop_test;
  end
endmodule // cpag_top_test
`default_nettype wire
